// File: hw/branch_pkg.sv
// Shared types and constants for the conditional relative branch execution unit.
package branch_pkg;

  // ---------------------------------------------------------------------------
  // Instruction forms and operand classes
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    JUMP_ON_BIT_SET_SHORT        = 4'h0,
    JUMP_ON_BIT_SET_LONG         = 4'h1,
    JUMP_ON_BIT_CLEAR_SHORT      = 4'h2,
    JUMP_ON_BIT_CLEAR_LONG       = 4'h3,
    JUMP_ON_BIT_SET_THEN_CLEAR_S = 4'h4,
    JUMP_ON_BIT_SET_THEN_CLEAR_L = 4'h5,
    JUMP_ON_ACC_ZERO             = 4'h6,
    JUMP_ON_ACC_NONZERO          = 4'h7,
    COMPARE_JUMP_ACC_DIR         = 4'h8,
    COMPARE_JUMP_ACC_IMM         = 4'h9,
    COMPARE_JUMP_REG_IMM         = 4'hA,
    COMPARE_JUMP_IND_IMM         = 4'hB,
    DECREMENT_JUMP_REG           = 4'hC,
    DECREMENT_JUMP_DIR           = 4'hD
  } form_t;

  typedef enum logic [1:0] {
    OPND_PLAIN  = 2'h0,
    OPND_PORT   = 2'h1,
    OPND_PERIPH = 2'h2
  } opnd_class_t;

  // ---------------------------------------------------------------------------
  // Encoding lengths and not-taken state counts, indexed by form
  // ---------------------------------------------------------------------------
  localparam int NUM_FORMS = 14;
  localparam logic [2:0] LEN_BIN [NUM_FORMS] =
    '{3'h3, 3'h5, 3'h3, 3'h5, 3'h3, 3'h5, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h3};
  localparam logic [2:0] LEN_SRC [NUM_FORMS] =
    '{3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h4, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h3, 3'h3};
  localparam logic [3:0] NT_BIN [NUM_FORMS] =
    '{4'h2, 4'h4, 4'h2, 4'h4, 4'h4, 4'h7, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h2, 4'h3};
  localparam logic [3:0] NT_SRC [NUM_FORMS] =
    '{4'h2, 4'h3, 4'h2, 4'h3, 4'h4, 4'h6, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h3, 4'h3};

  // State penalties.
  localparam logic [3:0] TAKEN_EXTRA     = 4'h3;
  localparam logic [3:0] PORT_EXTRA      = 4'h1;
  localparam logic [3:0] PERIPH_EXTRA    = 4'h2;
  localparam logic [3:0] DEC_PORT_EXTRA  = 4'h2;

  // Reset values.
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [3:0]  COUNT_RESET = 4'h0;

  // ---------------------------------------------------------------------------
  // Request and result carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    form_t       form;
    logic        source_mode;
    opnd_class_t opnd_class;
    logic [15:0] pc;
    logic [7:0]  rel;
    logic        bit_val;
    logic [7:0]  accumulator;
    logic [7:0]  src1;
    logic [7:0]  src2;
    logic [7:0]  dest;
  } branch_req_t;

  typedef struct packed {
    logic        taken;
    logic [15:0] next_pc;
    logic        carry_we;
    logic        carry_flag;
    logic        bit_clear;
    logic        dest_we;
    logic [7:0]  dest_val;
    logic [2:0]  length;
    logic [3:0]  states;
  } branch_res_t;

endpackage

// File: hw/branch_timing.sv
// Length and state-count lookup for one conditional branch.
`timescale 1ns/1ps
module branch_timing (
  input  wire branch_pkg::form_t       form,        // Instruction form.
  input  wire logic                    source_mode, // High in source decode mode.
  input  wire branch_pkg::opnd_class_t opnd_class,  // Operand kind.
  input  wire logic                    taken,       // Branch is taken.
  output logic [2:0]                   length,      // Encoding length in bytes.
  output logic [3:0]                   states       // Execution states.
);

  logic [3:0] base;
  logic [3:0] penalty;
  logic       bit_or_cmp;

  // Base length and not-taken cost per form and decode mode.
  // table lookup
  always_comb
  begin
    length = source_mode ? branch_pkg::LEN_SRC[form] : branch_pkg::LEN_BIN[form];
    base   = source_mode ? branch_pkg::NT_SRC[form] : branch_pkg::NT_BIN[form];
  end

  // Forms that read a direct bit or a direct compare operand.
  assign bit_or_cmp = (form <= branch_pkg::JUMP_ON_BIT_SET_THEN_CLEAR_L) ||
                      (form == branch_pkg::COMPARE_JUMP_ACC_DIR);

  // Extra states for port and peripheral register operands.
  always_comb
  begin
    penalty = 4'h0;
    if (bit_or_cmp && opnd_class == branch_pkg::OPND_PORT)
      penalty = branch_pkg::PORT_EXTRA;
    else if (bit_or_cmp && opnd_class == branch_pkg::OPND_PERIPH)
      penalty = branch_pkg::PERIPH_EXTRA;
    else if (form == branch_pkg::DECREMENT_JUMP_DIR && opnd_class == branch_pkg::OPND_PORT)
      penalty = branch_pkg::DEC_PORT_EXTRA;
  end

  assign states = base + penalty + (taken ? branch_pkg::TAKEN_EXTRA : 4'h0);

endmodule

// File: hw/conditional_branch_exec.sv
// Execution unit for the conditional relative branch instructions.
`timescale 1ns/1ps
module conditional_branch_exec (
  input  wire logic                    sys_clk,    // Core clock.
  input  wire logic                    reset,      // Synchronous reset, active high.
  input  wire logic                    start,      // Request strobe, one cycle.
  input  wire branch_pkg::branch_req_t req,        // Request fields.
  output logic                         ready,      // Unit can take a request.
  output logic                         done,       // Result valid, one cycle.
  output branch_pkg::branch_res_t      res         // Registered result.
);

  // ---------------------------------------------------------------------------
  // Operation
  // ---------------------------------------------------------------------------
  // A request is taken at the rising edge where start and ready are both high.
  // The whole outcome is worked out from the request fields in that cycle and
  // registered at once, so the caller may change the fields afterwards.
  // The unit then stays busy for as many cycles as the branch costs states:
  // with a total cost of N, done is high in the Nth cycle after the accept
  // edge and ready returns in the cycle after that.
  // A start given while the unit is busy is ignored without any indication.
  // Only one request is in flight at a time; nothing is queued or buffered.
  // The cost already holds the taken penalty and any operand penalty, so the
  // shortest run is two cycles and the longest twelve.
  // The unit performs no memory access of its own: the caller writes the
  // tested bit, the carry flag and the decremented operand back from the
  // result, using the write enables, once done is seen.
  // The result fields hold their values until the next request is taken.
  // The two unused form codes give a branch that is never taken; their
  // length and cost are not defined and must not be relied on.

  // ---------------------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------------------
  // Idle, counting and final state of a run.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_LAST = 2'b11
  } state_t;

  state_t                  state_q;
  state_t                  state_d;
  logic [3:0]              count_q;
  branch_pkg::branch_res_t res_q;
  branch_pkg::branch_res_t res_d;

  logic        taken;
  logic [15:0] seq_pc;
  logic [15:0] target_pc;
  logic [7:0]  dec_val;
  logic [2:0]  len;
  logic [3:0]  states;
  logic [15:0] rel_ext;
  logic        accept;

  // ---------------------------------------------------------------------------
  // Form groups
  // ---------------------------------------------------------------------------

  // The two forms that clear the bit they test when they branch.
  function automatic logic is_set_then_clear(input branch_pkg::form_t form);
    is_set_then_clear = (form == branch_pkg::JUMP_ON_BIT_SET_THEN_CLEAR_S) ||
                        (form == branch_pkg::JUMP_ON_BIT_SET_THEN_CLEAR_L);
  endfunction

  // The four compare forms, the only ones that touch the carry flag.
  function automatic logic is_compare(input branch_pkg::form_t form);
    is_compare = (form == branch_pkg::COMPARE_JUMP_ACC_DIR) ||
                 (form == branch_pkg::COMPARE_JUMP_ACC_IMM) ||
                 (form == branch_pkg::COMPARE_JUMP_REG_IMM) ||
                 (form == branch_pkg::COMPARE_JUMP_IND_IMM);
  endfunction

  // The two decrement forms, the only ones that write an operand back.
  function automatic logic is_decrement(input branch_pkg::form_t form);
    is_decrement = (form == branch_pkg::DECREMENT_JUMP_REG) ||
                   (form == branch_pkg::DECREMENT_JUMP_DIR);
  endfunction

  // Widens the signed 8-bit displacement to the address width.
  function automatic logic [15:0] sign_extend(input logic [7:0] value);
    sign_extend = {{8{value[7]}}, value};
  endfunction

  // ---------------------------------------------------------------------------
  // Branch decision
  // ---------------------------------------------------------------------------

  // Operand minus one for the decrement forms.
  assign dec_val = req.dest - 8'h01;

  // Condition per form.
  // It is decided from the request fields as they stand in the accept cycle.
  always_comb
  begin
    taken = 1'b0;
    unique case (req.form)
      branch_pkg::JUMP_ON_BIT_SET_SHORT,
      branch_pkg::JUMP_ON_BIT_SET_LONG:          taken = req.bit_val;
      branch_pkg::JUMP_ON_BIT_CLEAR_SHORT,
      branch_pkg::JUMP_ON_BIT_CLEAR_LONG:        taken = ~req.bit_val;
      branch_pkg::JUMP_ON_BIT_SET_THEN_CLEAR_S,
      branch_pkg::JUMP_ON_BIT_SET_THEN_CLEAR_L:  taken = req.bit_val;
      branch_pkg::JUMP_ON_ACC_ZERO:              taken = (req.accumulator == 8'h00);
      branch_pkg::JUMP_ON_ACC_NONZERO:           taken = (req.accumulator != 8'h00);
      branch_pkg::COMPARE_JUMP_ACC_DIR,
      branch_pkg::COMPARE_JUMP_ACC_IMM,
      branch_pkg::COMPARE_JUMP_REG_IMM,
      branch_pkg::COMPARE_JUMP_IND_IMM:          taken = (req.src1 != req.src2);
      branch_pkg::DECREMENT_JUMP_REG,
      branch_pkg::DECREMENT_JUMP_DIR:            taken = (dec_val != 8'h00);
      default:                                   taken = 1'b0;
    endcase
  end

  // Length and cost lookup.
  branch_timing u_timing (
    .form        (req.form),
    .source_mode (req.source_mode),
    .opnd_class  (req.opnd_class),
    .taken       (taken),
    .length      (len),
    .states      (states)
  );

  // Sequential address first, then the signed displacement on a taken branch.
  // Both sums wrap at 16 bits, so a branch may cross either end of the space.
  // signed offset add
  assign rel_ext   = sign_extend(req.rel);
  assign seq_pc    = req.pc + {13'h0000, len};
  assign target_pc = seq_pc + rel_ext;

  // Result assembly, including the side effects of each form.
  always_comb
  begin
    res_d            = '0;
    res_d.taken      = taken;
    res_d.length     = len;
    res_d.states     = states;
    res_d.next_pc    = taken ? target_pc : seq_pc;
    res_d.carry_we   = is_compare(req.form);
    res_d.carry_flag = res_d.carry_we && (req.src1 < req.src2);
    res_d.bit_clear  = req.bit_val && is_set_then_clear(req.form);
    res_d.dest_we    = is_decrement(req.form);
    res_d.dest_val   = res_d.dest_we ? dec_val : 8'h00;
  end

  // ---------------------------------------------------------------------------
  // Sequencing over the state count
  // ---------------------------------------------------------------------------

  // A request is taken only while idle; a strobe during a run is dropped.
  assign accept = (state_q == ST_IDLE) && start;

  // Next-state logic: one clock cycle stands for one state.
  // The counter reads the states still to run, so the last one starts when it
  // has counted down to two; a run always lasts at least two states.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) state_d = (states == 4'h1) ? ST_LAST : ST_RUN;
      ST_RUN:  if (count_q == 4'h2) state_d = ST_LAST;
      ST_LAST: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Remaining-state counter, loaded with the total cost on a request.
  // The loaded cost already holds the taken and operand penalties.
  // cost counted out
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      count_q <= branch_pkg::COUNT_RESET;
    else if (accept)
      count_q <= states;
    else if (state_q != ST_IDLE)
      count_q <= count_q - 4'h1;
  end

  // Result captured when the request is taken and held until the next one.
  // Nothing is captured while busy, so a dropped strobe leaves the result alone.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      res_q         <= '0;
      res_q.next_pc <= branch_pkg::PC_RESET;
    end
    else if (accept)
      res_q <= res_d;
  end

  // Handshake outputs.
  // Both come straight from the state register, so neither adds a cycle.
  assign ready = (state_q == ST_IDLE);
  assign done  = (state_q == ST_LAST);
  assign res   = res_q;

endmodule

// File: dv/branch_props.sv
// Checker of branch result timing and outcome at the execution unit's ports.
`timescale 1ns/1ps
module branch_props (
  input  wire logic                    sys_clk, // Core clock.
  input  wire logic                    reset,   // Synchronous reset.
  input  wire logic                    start,   // Request strobe.
  input  wire branch_pkg::branch_req_t req,     // Request fields.
  input  wire logic                    ready,   // Unit idle.
  input  wire logic                    done,    // Result strobe.
  input  wire branch_pkg::branch_res_t res      // Result fields.
);
  branch_pkg::branch_req_t q_q;
  logic [3:0]              cnt_q;
  logic [3:0]              f;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // Counts cycles since acceptance, so cycle N of a run reads N.
  always_ff @(posedge sys_clk)
  begin
    if (reset) cnt_q <= 4'h0;
    else if (start && ready) cnt_q <= 4'h1;
    else if (!ready) cnt_q <= cnt_q + 4'h1;
  end
  // Keeps the accepted request; the caller may drop it afterwards.
  always_ff @(posedge sys_clk)
  begin
    if (start && ready) q_q <= req;
  end
  // Form code groups: pairs share the upper bits.
  assign f = q_q.form;
  property p_time; done |-> cnt_q == res.states; endproperty
  a_time: assert property (p_time) else $error("done not at the state count");
  property p_busy; start && ready |=> !ready && !done; endproperty
  a_busy: assert property (p_busy) else $error("unit idle right after accept");
  property p_pc; done |-> res.next_pc == q_q.pc + 16'(res.length) + (res.taken ? {{8{q_q.rel[7]}}, q_q.rel} : 16'h0000);
  endproperty
  a_pc: assert property (p_pc) else $error("next address wrong");
  property p_st; done && q_q.opnd_class == 2'h0 |-> res.states == (q_q.source_mode ? branch_pkg::NT_SRC[f]
    : branch_pkg::NT_BIN[f]) + (res.taken ? 4'h3 : 4'h0); endproperty
  a_st: assert property (p_st) else $error("state count wrong");
  property p_set; done && f[3:1] == 3'h0 |-> res.taken == q_q.bit_val; endproperty
  a_set: assert property (p_set) else $error("bit set jump wrong");
  property p_clr; done && f[3:1] == 3'h1 |-> res.taken == !q_q.bit_val; endproperty
  a_clr: assert property (p_clr) else $error("bit clear jump wrong");
  property p_set_clr; done && f[3:1] == 3'h2 |-> res.taken == q_q.bit_val && res.bit_clear == q_q.bit_val; endproperty
  a_set_clr: assert property (p_set_clr) else $error("bit test and clear wrong");
  property p_acc; done && f[3:1] == 3'h3 |-> res.taken == ((q_q.accumulator == 8'h00) ^ f[0]); endproperty
  a_acc: assert property (p_acc) else $error("accumulator jump wrong");
  property p_cmp; done && f[3:2] == 2'h2 |-> res.carry_we && res.carry_flag == (q_q.src1 < q_q.src2)
    && res.taken == (q_q.src1 != q_q.src2); endproperty
  a_cmp: assert property (p_cmp) else $error("compare jump wrong");
  property p_dec; done && f[3:1] == 3'h6 |-> res.dest_we && res.dest_val == q_q.dest - 8'h01
    && res.taken == (q_q.dest != 8'h01); endproperty
  a_dec: assert property (p_dec) else $error("decrement jump wrong");
  c_taken: cover property (done && res.taken);
  c_not: cover property (done && !res.taken);
  c_clear: cover property (done && res.bit_clear);
endmodule
bind conditional_branch_exec branch_props props_u (.sys_clk(sys_clk), .reset(reset), .start(start), .req(req),
  .ready(ready), .done(done), .res(res));

// File: dv/fetch_model.sv
// Model of the fetch side that hands branch requests to the unit.
`timescale 1ns/1ps
module fetch_model (
  input  wire logic               sys_clk, // Core clock.
  input  wire logic               ready,   // Unit idle.
  input  wire logic               done,    // Result strobe.
  output logic                    start,   // Request strobe.
  output branch_pkg::branch_req_t req      // Request fields.
);
  initial
  begin
    start = 1'b0;
    req   = '0;
  end
  // Waits for idle, strobes once, scrambles the fields, then waits for the result.
  // Outputs are looked at on the falling edge, where they have settled.
  task automatic issue(input branch_pkg::branch_req_t r, output logic ok);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (ready !== 1'b1 && n++ < 20) @(negedge sys_clk);
    @(posedge sys_clk);
    start <= 1'b1;
    req   <= r;
    @(posedge sys_clk);
    start <= 1'b0;
    req   <= branch_pkg::branch_req_t'(~r);
    n = 0;
    @(negedge sys_clk);
    while (done !== 1'b1 && n++ < 20) @(negedge sys_clk);
    ok = (done === 1'b1);
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the conditional branch execution unit.
`timescale 1ns/1ps
module tb_top;
  logic                    sys_clk;
  logic                    reset = 1'b1;
  logic                    start;
  logic                    ready;
  logic                    done;
  branch_pkg::branch_req_t req;
  branch_pkg::branch_res_t res;
  int                      n_errors = 0;
  int                      compares = 0;
  int                      cycles = 0;
  logic [15:0]             pc_v = 16'h1000;
  logic [7:0]              rel_v = 8'h10;
  conditional_branch_exec dut_u (.sys_clk(sys_clk), .reset(reset), .start(start), .req(req), .ready(ready),
    .done(done), .res(res));
  fetch_model fetch_u (.sys_clk(sys_clk), .ready(ready), .done(done), .start(start), .req(req));
  // Clock and hang guard.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_errors++;
      end_sim();
    end
  end
  // Compares one value and counts it.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Runs one branch; a feeds bit, accumulator, first operand and destination.
  task automatic run(input logic [3:0] f, input logic sm, input logic [1:0] cls, input logic [7:0] a,
    input logic [7:0] b, input logic tk, input logic [2:0] len, input logic [3:0] st);
    branch_pkg::branch_req_t r;
    logic ok;
    r = '{branch_pkg::form_t'(f), sm, branch_pkg::opnd_class_t'(cls), pc_v, rel_v, a[0], a, a, b, a};
    fetch_u.issue(r, ok);
    check("done", 16'h0001, {15'h0000, ok});
    check("taken", {15'h0000, tk}, {15'h0000, res.taken});
    check("length", {13'h0000, len}, {13'h0000, res.length});
    check("states", {12'h000, st}, {12'h000, res.states});
    check("next_pc", pc_v + 16'(len) + (tk ? {{8{rel_v[7]}}, rel_v} : 16'h0000), res.next_pc);
    check("carry_we", {15'h0000, f[3:2] == 2'h2}, {15'h0000, res.carry_we});
    check("dest_we", {15'h0000, f[3:1] == 3'h6}, {15'h0000, res.dest_we});
    check("bit_clear", {15'h0000, f[3:1] == 3'h2 && a[0]}, {15'h0000, res.bit_clear});
  endtask
  task automatic t_bit();
    run(4'h0, 1'h0, 2'h0, 8'h01, 8'h00, 1'h1, 3'h3, 4'h5);
    run(4'h0, 1'h0, 2'h1, 8'h00, 8'h00, 1'h0, 3'h3, 4'h3);
    run(4'h2, 1'h0, 2'h0, 8'h00, 8'h00, 1'h1, 3'h3, 4'h5);
    run(4'h1, 1'h1, 2'h0, 8'h01, 8'h00, 1'h1, 3'h4, 4'h6);
    run(4'h3, 1'h0, 2'h2, 8'h01, 8'h00, 1'h0, 3'h5, 4'h6);
    $display("test bit jumps finished");
  endtask
  task automatic t_set_clr();
    run(4'h4, 1'h0, 2'h0, 8'h01, 8'h00, 1'h1, 3'h3, 4'h7);
    check("bit_clear", 16'h0001, {15'h0000, res.bit_clear});
    run(4'h5, 1'h0, 2'h0, 8'h00, 8'h00, 1'h0, 3'h5, 4'h7);
    check("bit_clear", 16'h0000, {15'h0000, res.bit_clear});
    run(4'h5, 1'h1, 2'h2, 8'h01, 8'h00, 1'h1, 3'h4, 4'hB);
    $display("test bit clear jumps finished");
  endtask
  task automatic t_acc();
    pc_v  = 16'hFFFF;
    rel_v = 8'hF0;
    run(4'h6, 1'h0, 2'h0, 8'h00, 8'h00, 1'h1, 3'h2, 4'h5);
    run(4'h7, 1'h1, 2'h0, 8'h00, 8'h00, 1'h0, 3'h2, 4'h2);
    run(4'h7, 1'h0, 2'h0, 8'h80, 8'h00, 1'h1, 3'h2, 4'h5);
    pc_v = 16'h1000;
    $display("test accumulator jumps finished");
  endtask
  task automatic t_cmp();
    run(4'h8, 1'h0, 2'h2, 8'h10, 8'h20, 1'h1, 3'h3, 4'h7);
    check("carry", 16'h0001, {15'h0000, res.carry_flag});
    run(4'h9, 1'h1, 2'h0, 8'h20, 8'h20, 1'h0, 3'h3, 4'h2);
    check("carry", 16'h0000, {15'h0000, res.carry_flag});
    run(4'hA, 1'h1, 2'h0, 8'h30, 8'h20, 1'h1, 3'h4, 4'h6);
    run(4'hA, 1'h0, 2'h0, 8'h20, 8'h20, 1'h0, 3'h3, 4'h2);
    run(4'hB, 1'h0, 2'h0, 8'h05, 8'h05, 1'h0, 3'h3, 4'h3);
    run(4'hB, 1'h1, 2'h0, 8'h00, 8'hFF, 1'h1, 3'h4, 4'h7);
    $display("test compare jumps finished");
  endtask
  task automatic t_dec();
    run(4'hC, 1'h0, 2'h0, 8'h01, 8'h00, 1'h0, 3'h2, 4'h2);
    check("dest_val", 16'h0000, {8'h00, res.dest_val});
    run(4'hD, 1'h0, 2'h1, 8'h00, 8'h00, 1'h1, 3'h3, 4'h8);
    check("dest_val", 16'h00FF, {8'h00, res.dest_val});
    run(4'hD, 1'h1, 2'h0, 8'h02, 8'h00, 1'h1, 3'h3, 4'h6);
    $display("test decrement jumps finished");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    check("reset_state", 16'h0002, {14'h0000, ready, done});
    check("reset_res", 16'h0000, 16'(res));
    t_bit();
    t_set_clr();
    t_acc();
    t_cmp();
    t_dec();
    end_sim();
  end
endmodule
